// File: shared/btc_pkg.sv
// Package of the BCD time and calendar core: register map, field layout,
// reset values, counter limits and the carrier struct.
// Assumes a single 200 MHz system clock and a 32768 Hz oscillator pin.
package btc_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_SEC = 4'h0;
    localparam logic [3:0] ADDR_MIN = 4'h1;
    localparam logic [3:0] ADDR_HOUR = 4'h2;
    localparam logic [3:0] ADDR_WDAY = 4'h3;
    localparam logic [3:0] ADDR_DATE = 4'h4;
    localparam logic [3:0] ADDR_MONTH = 4'h5;
    localparam logic [3:0] ADDR_YEAR = 4'h6;
    localparam logic [3:0] ADDR_SCRATCH = 4'h7;
    localparam logic [3:0] ADDR_EXT = 4'hD;
    localparam logic [3:0] ADDR_RUN = 4'hF;

    // Writable bits of each register; all other bits read as zero.
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_WDAY = 8'h7F;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] MASK_EXT = 8'h0F;
    localparam logic [7:0] MASK_RUN = 8'h01;

    // Field positions in the extension and run registers.
    localparam int unsigned RATE_LSB = 2;
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned STOP_BIT = 0;

    // Reset values.
    localparam logic [7:0] RST_SEC = 8'h00;
    localparam logic [7:0] RST_MIN = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_WDAY = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h01;
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [7:0] RST_EXT = 8'h00;

    // BCD counter limits.
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] ZERO_FIRST = 8'h00;
    localparam logic [7:0] ONE_FIRST = 8'h01;
    localparam logic [7:0] DAYS_LONG = 8'h31;
    localparam logic [7:0] DAYS_SHORT = 8'h30;
    localparam logic [7:0] DAYS_FEB = 8'h28;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_NOV = 8'h11;
    localparam logic [7:0] WDAY_LAST = 8'h40;

    // Oscillator divider: bit k toggles at 32768 / 2^(k+1) Hz.
    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned DIV_W = 15;
    localparam int unsigned DIV_STOP_LSB = 3;
    localparam int unsigned DIV_1K_BIT = 4;
    localparam int unsigned DIV_1HZ_BIT = 14;
    localparam int unsigned DIV_4K_W = 3;
    localparam int unsigned DIV_64_W = 9;

    typedef enum logic [1:0] {
        RATE_OSC = 2'b00,
        RATE_1K = 2'b01,
        RATE_1HZ = 2'b10,
        RATE_OSC_ALT = 2'b11
    } btc_rate_type;

    typedef enum logic [1:0] {
        SRC_4K = 2'b00,
        SRC_64 = 2'b01,
        SRC_SEC = 2'b10,
        SRC_MIN = 2'b11
    } btc_src_type;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } btc_cal_type;

endpackage

// File: src/btc_core.sv
// BCD time and calendar core with scratch byte, clock-output rate select
// and timer source select, reached over a plain register port.
// Assumes the oscillator pin is asynchronous to ref_clk_i and far slower.
`timescale 1ns/1ps

// How it works
// [RL1] Rate field picks 32768, 1024 or 1 Hz
// [RL2] Source field picks 4096 Hz, 64 Hz, second, minute
// [RL3] Protected bits ignore writes, read zero
// [RL4] Scratch byte stores any written value
// [RL5] Time counters hold BCD, top bits zero
// [RL6] Seconds count 00 to 59, wrap
// [RL7] Minutes count 00 to 59, wrap
// [RL8] Hours count 00 to 23, wrap
// [RL9] Weekday one-hot rotates left, 40h to 01h
// [RL10] Sunday 01h through Saturday 40h
// [RL11] Calendar in BCD, years 2000 to 2099
// [RL12] Date wraps after 31, 30 or 28
// [RL13] Year multiple of four gives February 29
// [RL14] Month counts 01 to 12, wrap
// [RL15] Year counts 00 to 99, wrap
// [RL16] Host writes only valid BCD times
// [RL17] Host writes only valid dates, one weekday bit
// [RL18] Stop freezes counters, resets 2048 Hz..1 Hz stages
// [RL19] Each wrap carries into the next counter
// [RL20] All rates divided from the 32768 Hz oscillator
module btc_core (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic osc_clk_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic clock_output_pin_o,
    output logic timer_src_tick_o
);

    // BCD increment with wrap from last back to first.
    function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        logic [7:0] r;
        r = 8'h00;
        if (v == last) begin
            r = first;
        end else if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction

    // A BCD year is a multiple of four when the tens digit is even and the
    // units are 0, 4 or 8, or the tens digit is odd and the units are 2 or 6.
    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = 1'b0;
        if (y[4] == 1'b0) begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return r;
    endfunction

    // Last date of the month held in BCD.
    function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] r;
        r = btc_pkg::DAYS_LONG;
        case (m)
            btc_pkg::MONTH_FEB: begin
                r = is_leap(y) ? btc_pkg::DAYS_FEB_LEAP : btc_pkg::DAYS_FEB; // RL13
            end
            btc_pkg::MONTH_APR, btc_pkg::MONTH_JUN, btc_pkg::MONTH_SEP, btc_pkg::MONTH_NOV: begin
                r = btc_pkg::DAYS_SHORT;
            end
            default: begin
                r = btc_pkg::DAYS_LONG;
            end
        endcase
        return r;
    endfunction

    // Oscillator pin synchroniser and edge detect.
    logic osc_meta_ff;
    logic osc_sync_ff;
    logic osc_prev_ff;
    logic osc_rise;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else begin
            osc_meta_ff <= osc_clk_i;
            osc_sync_ff <= osc_meta_ff;
            osc_prev_ff <= osc_sync_ff;
        end
    end

    assign osc_rise = osc_sync_ff && !osc_prev_ff;

    // Control registers.
    logic [7:0] ext_ff;
    logic stop_ff;
    logic [7:0] scratch_ff;
    logic [7:0] nxt_ext;
    logic nxt_stop;
    logic [7:0] nxt_scratch;
    btc_pkg::btc_rate_type rate;
    btc_pkg::btc_src_type src;

    assign rate = btc_pkg::btc_rate_type'(ext_ff[btc_pkg::RATE_LSB +: 2]);
    assign src = btc_pkg::btc_src_type'(ext_ff[btc_pkg::SRC_LSB +: 2]);

    always_comb begin
        nxt_ext = ext_ff;
        nxt_stop = stop_ff;
        nxt_scratch = scratch_ff;
        if (wr_i) begin
            case (addr_i)
                btc_pkg::ADDR_EXT: begin
                    nxt_ext = wdata_i & btc_pkg::MASK_EXT; // RL3
                end
                btc_pkg::ADDR_RUN: begin
                    nxt_stop = wdata_i[btc_pkg::STOP_BIT];
                end
                btc_pkg::ADDR_SCRATCH: begin
                    nxt_scratch = wdata_i; // RL4
                end
                default: begin
                    nxt_ext = ext_ff;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_ff <= btc_pkg::RST_EXT;
            stop_ff <= 1'b0;
            scratch_ff <= btc_pkg::RST_SCRATCH;
        end else begin
            ext_ff <= nxt_ext;
            stop_ff <= nxt_stop;
            scratch_ff <= nxt_scratch;
        end
    end

    // Divider chain; the 2048 Hz to 1 Hz stages are held clear during stop.
    logic [btc_pkg::DIV_W-1:0] div_ff;
    logic [btc_pkg::DIV_W-1:0] nxt_div;
    logic sec_tick;
    logic tick_4k;
    logic tick_64;

    always_comb begin
        nxt_div = div_ff;
        if (osc_rise) begin
            nxt_div = div_ff + 15'h0001; // RL20
        end
        if (stop_ff) begin
            nxt_div[btc_pkg::DIV_W-1:btc_pkg::DIV_STOP_LSB] = '0; // RL18
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign sec_tick = osc_rise && (div_ff == '1) && !stop_ff; // RL18
    assign tick_4k = osc_rise && (div_ff[btc_pkg::DIV_4K_W-1:0] == '1); // RL20
    assign tick_64 = osc_rise && (div_ff[btc_pkg::DIV_64_W-1:0] == '1) && !stop_ff;

    // Time and calendar counters.
    btc_pkg::btc_cal_type cal_ff;
    btc_pkg::btc_cal_type nxt_cal;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic date_wrap;
    logic month_wrap;

    assign sec_wrap = sec_tick && (cal_ff.sec == btc_pkg::SEC_LAST);
    assign min_wrap = sec_wrap && (cal_ff.min == btc_pkg::MIN_LAST); // RL19
    assign hour_wrap = min_wrap && (cal_ff.hour == btc_pkg::HOUR_LAST);
    assign date_wrap = hour_wrap && (cal_ff.date == last_date(cal_ff.month, cal_ff.year));
    assign month_wrap = date_wrap && (cal_ff.month == btc_pkg::MONTH_LAST);

    always_comb begin
        nxt_cal = cal_ff;
        if (sec_tick) begin
            nxt_cal.sec = bcd_next(cal_ff.sec, btc_pkg::SEC_LAST, btc_pkg::ZERO_FIRST); // RL6
        end
        if (sec_wrap) begin
            nxt_cal.min = bcd_next(cal_ff.min, btc_pkg::MIN_LAST, btc_pkg::ZERO_FIRST); // RL7
        end
        if (min_wrap) begin
            nxt_cal.hour = bcd_next(cal_ff.hour, btc_pkg::HOUR_LAST, btc_pkg::ZERO_FIRST); // RL8
        end
        if (hour_wrap) begin
            // RL9
            nxt_cal.wday = (cal_ff.wday == btc_pkg::WDAY_LAST) ? btc_pkg::ONE_FIRST
                                                               : {1'b0, cal_ff.wday[5:0], 1'b0};
            // RL12
            nxt_cal.date = bcd_next(cal_ff.date, last_date(cal_ff.month, cal_ff.year),
                                    btc_pkg::ONE_FIRST);
        end
        if (date_wrap) begin
            nxt_cal.month = bcd_next(cal_ff.month, btc_pkg::MONTH_LAST, btc_pkg::ONE_FIRST); // RL14
        end
        if (month_wrap) begin
            nxt_cal.year = bcd_next(cal_ff.year, btc_pkg::YEAR_LAST, btc_pkg::ZERO_FIRST); // RL15
        end
        // A host write takes that field over; other fields still carry (RL19).
        if (wr_i) begin
            case (addr_i)
                btc_pkg::ADDR_SEC: begin
                    nxt_cal.sec = wdata_i & btc_pkg::MASK_SEC; // RL5
                end
                btc_pkg::ADDR_MIN: begin
                    nxt_cal.min = wdata_i & btc_pkg::MASK_MIN; // RL5
                end
                btc_pkg::ADDR_HOUR: begin
                    nxt_cal.hour = wdata_i & btc_pkg::MASK_HOUR; // RL5
                end
                btc_pkg::ADDR_WDAY: begin
                    nxt_cal.wday = wdata_i & btc_pkg::MASK_WDAY; // RL10
                end
                btc_pkg::ADDR_DATE: begin
                    nxt_cal.date = wdata_i & btc_pkg::MASK_DATE; // RL11
                end
                btc_pkg::ADDR_MONTH: begin
                    nxt_cal.month = wdata_i & btc_pkg::MASK_MONTH; // RL3
                end
                btc_pkg::ADDR_YEAR: begin
                    nxt_cal.year = wdata_i & btc_pkg::MASK_YEAR; // RL11
                end
                default: begin
                    nxt_cal.sec = nxt_cal.sec;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_ff <= '{btc_pkg::RST_SEC, btc_pkg::RST_MIN, btc_pkg::RST_HOUR, btc_pkg::RST_WDAY,
                        btc_pkg::RST_DATE, btc_pkg::RST_MONTH, btc_pkg::RST_YEAR};
        end else begin
            cal_ff <= nxt_cal;
        end
    end

    // Clock-output pin and timer source tick.
    logic clkout_ff;
    logic src_tick_ff;
    logic nxt_clkout;
    logic nxt_src_tick;

    always_comb begin
        case (rate)
            btc_pkg::RATE_1K: begin
                nxt_clkout = div_ff[btc_pkg::DIV_1K_BIT]; // RL1
            end
            btc_pkg::RATE_1HZ: begin
                nxt_clkout = div_ff[btc_pkg::DIV_1HZ_BIT]; // RL1
            end
            default: begin
                nxt_clkout = osc_sync_ff; // RL1
            end
        endcase
        case (src)
            btc_pkg::SRC_4K: begin
                nxt_src_tick = tick_4k; // RL2
            end
            btc_pkg::SRC_64: begin
                nxt_src_tick = tick_64; // RL2
            end
            btc_pkg::SRC_SEC: begin
                nxt_src_tick = sec_tick; // RL2
            end
            default: begin
                nxt_src_tick = sec_wrap; // RL2
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clkout_ff <= 1'b0;
            src_tick_ff <= 1'b0;
        end else begin
            clkout_ff <= nxt_clkout;
            src_tick_ff <= nxt_src_tick;
        end
    end

    assign clock_output_pin_o = clkout_ff;
    assign timer_src_tick_o = src_tick_ff;

    // Read port: data stands in the cycle after the strobe only.
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                btc_pkg::ADDR_SEC: nxt_rdata = cal_ff.sec;
                btc_pkg::ADDR_MIN: nxt_rdata = cal_ff.min;
                btc_pkg::ADDR_HOUR: nxt_rdata = cal_ff.hour;
                btc_pkg::ADDR_WDAY: nxt_rdata = cal_ff.wday;
                btc_pkg::ADDR_DATE: nxt_rdata = cal_ff.date;
                btc_pkg::ADDR_MONTH: nxt_rdata = cal_ff.month;
                btc_pkg::ADDR_YEAR: nxt_rdata = cal_ff.year;
                btc_pkg::ADDR_SCRATCH: nxt_rdata = scratch_ff; // RL4
                btc_pkg::ADDR_EXT: nxt_rdata = ext_ff;
                btc_pkg::ADDR_RUN: nxt_rdata = {7'h00, stop_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;

    // Checks.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic wr_time;
    assign wr_time = wr_i && (addr_i <= btc_pkg::ADDR_YEAR);

    sequence s_scratch_write;
        wr_i && (addr_i == btc_pkg::ADDR_SCRATCH);
    endsequence

    sequence s_scratch_read;
        rd_i && (addr_i == btc_pkg::ADDR_SCRATCH) && !wr_i;
    endsequence

    a_sec_wrap_carry: assert property ( // RL6
        sec_tick && cal_ff.sec == 8'h59 && !wr_time
        |=> cal_ff.sec == 8'h00 && cal_ff.min != $past(cal_ff.min))
        else $error("seconds did not wrap into minutes");

    a_sec_bcd_step: assert property ( // RL5
        sec_tick && !wr_time |=> cal_ff.sec[3:0] <= 4'h9 && cal_ff.sec <= 8'h59)
        else $error("seconds did not step in BCD");

    a_min_wrap_carry: assert property ( // RL7
        sec_wrap && cal_ff.min == 8'h59 && !wr_time
        |=> cal_ff.min == 8'h00 && cal_ff.hour != $past(cal_ff.hour))
        else $error("minutes did not wrap into hours");

    a_hour_wrap_day: assert property ( // RL8
        min_wrap && cal_ff.hour == 8'h23 && cal_ff.wday == 8'h40 && !wr_time
        |=> cal_ff.hour == 8'h00 && cal_ff.wday == 8'h01)
        else $error("hour wrap did not rotate the weekday");

    a_feb_leap_day: assert property ( // RL13
        hour_wrap && cal_ff.month == 8'h02 && cal_ff.date == 8'h28 && cal_ff.year == 8'h04 && !wr_time
        |=> cal_ff.date == 8'h29 && cal_ff.month == 8'h02)
        else $error("leap February skipped the 29th");

    a_feb_normal_end: assert property ( // RL12
        hour_wrap && cal_ff.month == 8'h02 && cal_ff.date == 8'h28 && cal_ff.year == 8'h05 && !wr_time
        |=> cal_ff.date == 8'h01 && cal_ff.month == 8'h03)
        else $error("normal February did not end on the 28th");

    a_short_month_end: assert property ( // RL19
        hour_wrap && cal_ff.month == 8'h04 && cal_ff.date == 8'h30 && !wr_time
        |=> cal_ff.date == 8'h01 && cal_ff.month == 8'h05)
        else $error("April did not end on the 30th");

    a_year_wrap_end: assert property ( // RL15
        month_wrap && cal_ff.year == 8'h99 && !wr_time
        |=> cal_ff.year == 8'h00 && cal_ff.month == 8'h01 && cal_ff.date == 8'h01)
        else $error("year did not wrap from 99 to 00");

    a_stop_freeze_cal: assert property ( // RL18
        (stop_ff && !wr_time) [*2] |-> $stable(cal_ff) && div_ff[btc_pkg::DIV_W-1:btc_pkg::DIV_STOP_LSB] == '0)
        else $error("counters moved while stopped");

    a_hour_top_zero: assert property ( // RL3
        rd_i && addr_i == btc_pkg::ADDR_HOUR |=> rdata_o[7:6] == 2'b00)
        else $error("hour register top bits not zero");

    a_scratch_keep: assert property ( // RL4
        s_scratch_write ##1 s_scratch_read |=> rdata_o == $past(wdata_i, 2))
        else $error("scratch byte lost its value");

    a_src_4k_tick: assert property ( // RL2
        src == btc_pkg::SRC_4K && tick_4k && !wr_i |=> timer_src_tick_o ##1 !timer_src_tick_o)
        else $error("4096 Hz source tick missing");

endmodule

// File: verif/btc_osc_model.sv
// Oscillator source standing in for the 32768 Hz crystal on osc_clk_i.
// Assumes it is clocked by the bench clock; HALF sets the half period in clock cycles.
`timescale 1ns/1ps
module btc_osc_model #(
    parameter int HALF = 1
) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic osc_o
);
    int cnt;

    initial begin
        osc_o = 1'b0;
        cnt = 0;
    end

    // The oscillator idles low while not running, so no stale edge is left behind.
    always @(posedge clk_i) begin
        if (!run_i) begin
            osc_o <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            osc_o <= ~osc_o;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// File: verif/testbench.sv
// Self-checking bench of the time and calendar core over its register port.
// Assumes the oscillator model runs at half the bench clock rate, so one second takes 65536 cycles.
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic osc_run = 1'b0;
    logic osc_clk;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic clkout;
    logic src_tick;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] val;
    int n;
    int k;
    // Valid values with every protected bit set, and what must read back.
    localparam logic [7:0] MASKIN [8] = '{8'hD9, 8'hD9, 8'hE3, 8'hC0, 8'hF1, 8'hF2, 8'h99, 8'hFF};
    localparam logic [7:0] WMASK [8] = '{8'h59, 8'h59, 8'h23, 8'h40, 8'h31, 8'h12, 8'h99, 8'hFF};
    localparam int RATE_GAP [4] = '{2, 64, 0, 2};
    localparam int SRC_GAP [2] = '{16, 1024};
    localparam logic [7:0] PRESET [7] = '{8'h59, 8'h59, 8'h23, 8'h40, 8'h31, 8'h12, 8'h99};
    localparam logic [7:0] ROLLED [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

    always #2.5 ref_clk_i = ~ref_clk_i;

    btc_osc_model #(.HALF(1)) osc (.clk_i(ref_clk_i), .run_i(osc_run), .osc_o(osc_clk));

    btc_core dut (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .osc_clk_i(osc_clk),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .rdata_o(rdata),
        .clock_output_pin_o(clkout),
        .timer_src_tick_o(src_tick)
    );

    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Counts the cycles between two rising edges of the tick or the clock output; 0 if none is seen.
    task automatic gap(input bit pick, output int cnt);
        logic p;
        logic s;
        int r;
        int i;
        p = 1'b1;
        r = 0;
        cnt = 0;
        for (i = 0; i < 3000 && r < 2; i++) begin
            @(posedge ref_clk_i);
            #1;
            s = pick ? src_tick : clkout;
            if (r == 1) begin
                cnt++;
            end
            if (s === 1'b1 && p === 1'b0) begin
                r++;
            end
            p = s;
        end
    endtask

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        osc_run <= 1'b1;
        for (k = 0; k < 8; k++) begin
            wr_reg(k[3:0], MASKIN[k]);
            rd_reg(k[3:0], val);
            chk("write_mask", 16'(val), 16'(WMASK[k]));
        end
        // Write then read the scratch byte with no idle cycle between the strobes.
        @(posedge ref_clk_i);
        wr <= 1'b1;
        addr <= btc_pkg::ADDR_SCRATCH;
        wdata <= 8'h00;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        val = rdata;
        chk("scratch", 16'(val), 16'h0000);
        for (k = 0; k < 7; k++) begin
            wr_reg(btc_pkg::ADDR_WDAY, 8'(8'h01 << k));
            rd_reg(btc_pkg::ADDR_WDAY, val);
            chk("weekday", 16'(val), 16'(8'h01 << k));
        end
        wr_reg(4'h8, 8'hA5);
        rd_reg(4'h8, val);
        chk("unmapped", 16'(val), 16'h0000);
        wr_reg(btc_pkg::ADDR_EXT, 8'hFF);
        rd_reg(btc_pkg::ADDR_EXT, val);
        chk("ext_mask", 16'(val), 16'h000F);
        for (k = 0; k < 4; k++) begin
            if (k != 2) begin
                wr_reg(btc_pkg::ADDR_EXT, 8'(k << 2));
                gap(1'b0, n);
                chk("clkout_gap", 16'(n), 16'(RATE_GAP[k]));
            end
        end
        for (k = 0; k < 2; k++) begin
            wr_reg(btc_pkg::ADDR_EXT, 8'(k));
            gap(1'b1, n);
            chk("tick_gap", 16'(n), 16'(SRC_GAP[k]));
        end
        // Under stop the 64 Hz source and the 1 Hz output stand still, the 4096 Hz source runs on.
        wr_reg(btc_pkg::ADDR_RUN, 8'h01);
        wr_reg(btc_pkg::ADDR_EXT, 8'h09);
        gap(1'b1, n);
        chk("stopped_gap", 16'(n), 16'h0000);
        chk("stopped_1hz", 16'(clkout), 16'h0000);
        wr_reg(btc_pkg::ADDR_EXT, 8'h08);
        gap(1'b1, n);
        chk("stopped_4k_gap", 16'(n), 16'h0010);
        for (k = 0; k < 7; k++) begin
            wr_reg(k[3:0], PRESET[k]);
        end
        wr_reg(btc_pkg::ADDR_EXT, 8'h03);
        wr_reg(btc_pkg::ADDR_RUN, 8'h00);
        for (k = 0; k < 70000 && src_tick !== 1'b1; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk("minute_tick", 16'(src_tick), 16'h0001);
        for (k = 0; k < 7; k++) begin
            rd_reg(k[3:0], val);
            chk("rollover", 16'(val), 16'(ROLLED[k]));
        end
        final_report();
    end
endmodule
